// File: rtl/pci_config_command_class.sv
// What this block does
// (R1) The command and status word sits at offset 04h, enables low and status high.
// (R2) Bit 20 reads back bit 19 of the power-management option register, 1 meaning a list exists.
// (R3) With bit 8 set (default) an address-phase parity error drives the system error pin.
// (R4) Bit 6 (default 0) makes detected parity errors raise system error status, else ignored.
// (R5) Bus mastering is allowed only while bit 2 is 1 (default 1).
// (R6) Memory decode is allowed only while bit 1 is 1 (default 1).
// (R7) Bit 0 defaults to 1; 0 enables I/O decode and 1 disables it.
// (R8) Bits 31..24 of the class word read 02h, a network controller.
// (R9) Bits 23..16 of the class word read 00h, an ethernet controller.
// (R10) The low byte of the class word is a fixed revision, bits 15..8 reserved.
// (R11) Reserved command bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
`include "cfg_cmd_defs.svh"
module pci_config_command_class
    import cfg_cmd_pkg::*;
#(
    parameter logic [7:0] REVISION_ID = 8'h01  // arbitrary value
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_nrst,
    // configuration access
    input  wire logic        i_cfg_write,
    input  wire logic        i_cfg_read,
    input  wire cfg_ofs_t    i_cfg_offset,
    input  wire cfg_word_t   i_cfg_wdata,
    input  wire logic [3:0]  i_cfg_be,
    output var cfg_word_t    o_cfg_rdata,
    // neighbouring state
    input  wire logic        i_pmo_cap_bit,
    input  wire logic        i_addr_parity_err,
    input  wire logic        i_parity_err,
    input  wire logic        i_master_req,
    // decode and error outputs
    output logic             o_io_decode_en,
    output logic             o_mem_decode_en,
    output logic             o_master_grant_ok,
    output logic             o_serr_n,
    output logic             o_sys_err_event
);

    // stored command enables; lanes 2 and 3 hold nothing, bit 20 is a live mirror
    logic io_space_control_ff;
    logic memory_space_enable_ff;
    logic bus_master_enable_ff;
    logic parity_error_response_enable_ff;
    logic address_parity_serr_enable_ff;
    logic wr_cmd;
    cfg_word_t cmd_word;
    cfg_word_t class_word;
    cfg_word_t nxt_rdata;

    assign wr_cmd = i_cfg_write && (i_cfg_offset == `OFS_COMMAND_AND_STATUS); // [R1]

    // lane 0 enables; reserved bits 7 and 5..3 have no storage, so writes vanish [R11]
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            io_space_control_ff             <= `RST_IO_SPACE_CONTROL;    // [R7]
            memory_space_enable_ff          <= `RST_MEMORY_SPACE_ENABLE; // [R6]
            bus_master_enable_ff            <= `RST_BUS_MASTER_ENABLE;   // [R5]
            parity_error_response_enable_ff <= `RST_PARITY_RESP_ENABLE;  // [R4]
        end else if (wr_cmd && i_cfg_be[0]) begin
            io_space_control_ff             <= i_cfg_wdata[`BIT_IO_SPACE_CONTROL];    // [R7]
            memory_space_enable_ff          <= i_cfg_wdata[`BIT_MEMORY_SPACE_ENABLE]; // [R6]
            bus_master_enable_ff            <= i_cfg_wdata[`BIT_BUS_MASTER_ENABLE];   // [R5]
            parity_error_response_enable_ff <= i_cfg_wdata[`BIT_PARITY_RESP_ENABLE];  // [R4]
        end
    end

    // lane 1 holds only the address error enable; bits 15..9 are reserved [R11]
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            address_parity_serr_enable_ff <= `RST_ADDR_SERR_ENABLE;  // [R3]
        end else if (wr_cmd && i_cfg_be[1]) begin
            address_parity_serr_enable_ff <= i_cfg_wdata[`BIT_ADDR_SERR_ENABLE];  // [R3]
        end
    end

    // read images; status flags above bit 20 belong to a neighbouring block
    always_comb begin
        cmd_word = '0;                                                  // [R11]
        cmd_word[`BIT_IO_SPACE_CONTROL]    = io_space_control_ff;
        cmd_word[`BIT_MEMORY_SPACE_ENABLE] = memory_space_enable_ff;
        cmd_word[`BIT_BUS_MASTER_ENABLE]   = bus_master_enable_ff;
        cmd_word[`BIT_PARITY_RESP_ENABLE]  = parity_error_response_enable_ff;
        cmd_word[`BIT_ADDR_SERR_ENABLE]    = address_parity_serr_enable_ff;
        cmd_word[`BIT_NEW_CAPABILITIES]    = i_pmo_cap_bit;             // [R2]
        class_word = {`BASE_CLASS_NETWORK, `SUBCLASS_ETHERNET,          // [R8] [R9]
                      `CLASS_RESERVED_BYTE, REVISION_ID};               // [R10]
        case (i_cfg_offset)
            `OFS_COMMAND_AND_STATUS: nxt_rdata = cmd_word;
            `OFS_CLASS_AND_REVISION: nxt_rdata = class_word;
            default:                 nxt_rdata = '0;
        endcase
    end

    // read data registered: valid the cycle after i_cfg_read
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cfg_rdata <= '0;
        end else if (i_cfg_read) begin
            o_cfg_rdata <= nxt_rdata;
        end
    end

    // io decode; the control bit is inverted as the hardware defines it, so reset is off
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_io_decode_en <= 1'b0;
        end else begin
            o_io_decode_en <= !io_space_control_ff;  // [R7]
        end
    end

    // memory decode follows its enable one cycle late
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_mem_decode_en <= 1'b0;
        end else begin
            o_mem_decode_en <= memory_space_enable_ff;  // [R6]
        end
    end

    // master permission; a request while mastering is off is never granted
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_master_grant_ok <= 1'b0;
        end else begin
            o_master_grant_ok <= i_master_req && bus_master_enable_ff;  // [R5]
        end
    end

    // system error pin, active low; one low cycle per flagged address phase
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_serr_n <= 1'b1;
        end else begin
            o_serr_n <= !(i_addr_parity_err && address_parity_serr_enable_ff);  // [R3]
        end
    end

    // status pulse for the neighbouring status block; errors dropped while off
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_sys_err_event <= 1'b0;
        end else begin
            o_sys_err_event <= i_parity_err && parity_error_response_enable_ff;  // [R4]
        end
    end

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    a_serr_on_addr_err: assert property (   // [R3]
        i_addr_parity_err && address_parity_serr_enable_ff |=> !o_serr_n)
        else $error("serr not driven on address parity error");
    a_serr_quiet_off: assert property (     // [R3]
        !address_parity_serr_enable_ff |=> o_serr_n)
        else $error("serr driven while disabled");
    a_parity_resp_gate: assert property (   // [R4]
        o_sys_err_event |-> $past(i_parity_err) && $past(parity_error_response_enable_ff))
        else $error("system error event without enabled parity error");
    a_master_gate: assert property (        // [R5]
        o_master_grant_ok |-> $past(bus_master_enable_ff) && $past(i_master_req))
        else $error("master activity while disabled");
    a_mem_decode: assert property (         // [R6]
        wr_cmd && i_cfg_be[0] && !i_cfg_wdata[1] |=> ##1 !o_mem_decode_en)
        else $error("memory decode not disabled after write");
    a_io_inverted: assert property (        // [R7]
        wr_cmd && i_cfg_be[0] && i_cfg_wdata[0] |=> ##1 !o_io_decode_en)
        else $error("io decode not disabled by writing 1");
    a_newcap_mirror: assert property (      // [R2]
        i_cfg_read && i_cfg_offset == 8'h04 |=> o_cfg_rdata[20] == $past(i_pmo_cap_bit))
        else $error("new capabilities does not mirror option bit");
    a_class_code: assert property (         // [R8]
        i_cfg_read && i_cfg_offset == 8'h08 |=> o_cfg_rdata[31:8] == 24'h020000)
        else $error("class code wrong");
    a_reserved_zero: assert property (      // [R11]
        i_cfg_read && i_cfg_offset == 8'h04
        |=> o_cfg_rdata[19:9] == 11'h000 && !o_cfg_rdata[7] && o_cfg_rdata[5:3] == 3'h0)
        else $error("reserved command bits not zero");

    // read path: class fields, unmapped offsets and held data
    a_subclass_code: assert property (      // [R9]
        i_cfg_read && i_cfg_offset == 8'h08 |=> o_cfg_rdata[23:16] == 8'h00)
        else $error("subclass code wrong");
    a_revision_byte: assert property (      // [R10]
        i_cfg_read && i_cfg_offset == 8'h08 |=> o_cfg_rdata[7:0] == REVISION_ID)
        else $error("revision byte wrong");
    a_unmapped_zero: assert property (      // [R1]
        i_cfg_read && i_cfg_offset != 8'h04 && i_cfg_offset != 8'h08 |=> o_cfg_rdata == '0)
        else $error("unmapped offset did not read zero");
    a_rdata_holds: assert property (        // [R1]
        !i_cfg_read |=> $stable(o_cfg_rdata))
        else $error("read data changed without a read");

    // enables gate their outputs; parity response checked both ways, mastering only while off
    a_master_off: assert property (         // [R5]
        !bus_master_enable_ff |=> !o_master_grant_ok)
        else $error("grant while mastering disabled");
    a_sys_err_off: assert property (        // [R4]
        !parity_error_response_enable_ff |=> !o_sys_err_event)
        else $error("status pulse while parity response disabled");
    a_sys_err_on: assert property (         // [R4]
        i_parity_err && parity_error_response_enable_ff |=> o_sys_err_event)
        else $error("parity error not reported while enabled");

    // byte lanes: an unselected lane leaves its bits alone
    a_lane1_kept: assert property (         // [R11]
        wr_cmd && !i_cfg_be[1] |=> $stable(address_parity_serr_enable_ff))
        else $error("serr enable changed without its lane");
    a_lane0_kept: assert property (         // [R11]
        wr_cmd && !i_cfg_be[0]
        |=> $stable(memory_space_enable_ff) && $stable(bus_master_enable_ff))
        else $error("lane 0 enables changed without their lane");

    // main scenarios
    c_cmd_write: cover property (wr_cmd && i_cfg_be[0]);
    c_serr_pulse: cover property (!o_serr_n);
    c_sys_err: cover property (o_sys_err_event);
    c_class_read: cover property (i_cfg_read && i_cfg_offset == 8'h08);
    c_io_enabled: cover property (o_io_decode_en);

endmodule
`default_nettype wire

// File: rtl/cfg_cmd_defs.svh
`ifndef CFG_CMD_DEFS_SVH
`define CFG_CMD_DEFS_SVH

// configuration offsets (byte addresses)
`define OFS_COMMAND_AND_STATUS 8'h04
`define OFS_CLASS_AND_REVISION 8'h08

// command field positions
`define BIT_IO_SPACE_CONTROL    0
`define BIT_MEMORY_SPACE_ENABLE 1
`define BIT_BUS_MASTER_ENABLE   2
`define BIT_PARITY_RESP_ENABLE  6
`define BIT_ADDR_SERR_ENABLE    8
`define BIT_NEW_CAPABILITIES    20
`define BIT_PMO_CAP_PRESENT     19

// command reset values
`define RST_IO_SPACE_CONTROL    1'b1
`define RST_MEMORY_SPACE_ENABLE 1'b1
`define RST_BUS_MASTER_ENABLE   1'b1
`define RST_PARITY_RESP_ENABLE  1'b0
`define RST_ADDR_SERR_ENABLE    1'b1

// class code fields
`define BASE_CLASS_NETWORK      8'h02
`define SUBCLASS_ETHERNET       8'h00
`define CLASS_RESERVED_BYTE     8'h00

`endif

// File: rtl/cfg_cmd_pkg.sv
`default_nettype none
package cfg_cmd_pkg;
    typedef logic [31:0] cfg_word_t;
    typedef logic [7:0]  cfg_ofs_t;
endpackage
`default_nettype wire

// File: dv/cfg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model
    import cfg_cmd_pkg::*;
(
    // bus side
    input  wire logic      i_clock,
    input  wire cfg_word_t i_rdata,
    output logic           o_write,
    output logic           o_read,
    output var cfg_ofs_t   o_offset,
    output var cfg_word_t  o_wdata,
    output logic [3:0]     o_be
);
    // idle bus until the first access
    initial begin
        {o_write, o_read, o_offset, o_wdata, o_be} = '0;
    end
    // one strobe cycle; strobes then drop and offset, data and lanes are inverted so stale data never matches
    task automatic xfer(input logic wr, input cfg_ofs_t ofs, input cfg_word_t d,
                        input logic [3:0] be, output cfg_word_t q);
        @(negedge i_clock);
        o_write  = wr;
        o_read   = !wr;
        o_offset = ofs;
        o_wdata  = d;
        o_be     = be;
        @(negedge i_clock);
        o_write  = 1'b0;
        o_read   = 1'b0;
        o_offset = ~ofs;
        o_wdata  = ~d;
        o_be     = ~be;
        q        = i_rdata;
    endtask
endmodule
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
    import cfg_cmd_pkg::*;
;
    logic      clock = 0, nrst = 0, write, read, pmo = 0, aperr = 0, perr = 0, mreq = 1;
    logic      io_en, mem_en, mgo, serr_n, syserr;
    logic [3:0] be;
    cfg_ofs_t  offset;
    cfg_word_t wdata, rdata, q;
    int        fails = 0, tests_run = 0, cycles = 0;
    logic [1:0] sn, se;
    cfg_host_model u_host (.i_clock(clock), .i_rdata(rdata), .o_write(write),
        .o_read(read), .o_offset(offset), .o_wdata(wdata), .o_be(be));
    pci_config_command_class #(.REVISION_ID(8'h5c)) u_dut (.i_clock(clock), .i_nrst(nrst),
        .i_cfg_write(write), .i_cfg_read(read), .i_cfg_offset(offset), .i_cfg_wdata(wdata),
        .i_cfg_be(be), .o_cfg_rdata(rdata), .i_pmo_cap_bit(pmo), .i_addr_parity_err(aperr),
        .i_parity_err(perr), .i_master_req(mreq), .o_io_decode_en(io_en),
        .o_mem_decode_en(mem_en), .o_master_grant_ok(mgo), .o_serr_n(serr_n),
        .o_sys_err_event(syserr));
    // 40 MHz clock and a hang limit well above the run length
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic check(input string what, input cfg_word_t seen, input cfg_word_t exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one error pulse, then both outputs over the next two cycles
    task automatic pulse(input logic addr);
        @(negedge clock);
        aperr = addr;
        perr  = !addr;
        @(negedge clock);
        aperr = 1'b0;
        perr  = 1'b0;
        sn[0] = serr_n;
        se[0] = syserr;
        @(negedge clock);
        sn[1] = serr_n;
        se[1] = syserr;
    endtask
    task automatic t_reset();
        u_host.xfer(1'b0, 8'h04, 32'h0, 4'h0, q);
        check("cmd reset", q, 32'h0000_0107);
        check("io en", io_en, 1'b0);
        check("mem en", mem_en, 1'b1);
        check("grant", mgo, 1'b1);
        mreq = 1'b0;
        @(negedge clock);
        check("grant no req", mgo, 1'b0);
        mreq = 1'b1;
        u_host.xfer(1'b0, 8'h08, 32'h0, 4'h0, q);
        check("class", q, 32'h0200_005c);
        u_host.xfer(1'b0, 8'h0c, 32'h0, 4'h0, q);
        check("unmapped", q, 32'h0);
    endtask
    // read-only class word and reserved bits must not take writes
    task automatic t_write();
        pmo = 1'b1;
        u_host.xfer(1'b1, 8'h08, 32'hffff_ffff, 4'hf, q);
        u_host.xfer(1'b1, 8'h04, 32'hffef_fffe, 4'hf, q);
        u_host.xfer(1'b0, 8'h08, 32'h0, 4'h0, q);
        check("class ro", q, 32'h0200_005c);
        u_host.xfer(1'b0, 8'h04, 32'h0, 4'h0, q);
        check("cmd ones", q, 32'h0010_0146);
        pmo = 1'b0;
        u_host.xfer(1'b1, 8'h04, 32'h0, 4'h1, q);
        u_host.xfer(1'b0, 8'h04, 32'h0, 4'h0, q);
        check("cmd lane0", q, 32'h0000_0100);
        check("mem off", mem_en, 1'b0);
        check("io on", io_en, 1'b1);
        check("grant off", mgo, 1'b0);
    endtask
    // error paths with each enable on and off
    task automatic t_errors();
        pulse(1'b0);
        check("perr ignored", se, 2'b00);
        pulse(1'b1);
        check("serr once", sn, 2'b10);
        u_host.xfer(1'b1, 8'h04, 32'h0000_0040, 4'h3, q);
        pulse(1'b0);
        check("syserr once", se, 2'b01);
        pulse(1'b1);
        check("serr masked", sn, 2'b11);
    endtask
    // reset in mid-run brings every enable back, then a lane 1 only write
    task automatic t_rereset();
        @(negedge clock);
        nrst = 1'b0;
        @(negedge clock);
        check("rst rdata", rdata, 32'h0);
        check("rst io", io_en, 1'b0);
        check("rst serr", serr_n, 1'b1);
        nrst = 1'b1;
        u_host.xfer(1'b0, 8'h04, 32'h0, 4'h0, q);
        check("cmd rereset", q, 32'h0000_0107);
        check("grant back", mgo, 1'b1);
        u_host.xfer(1'b1, 8'h04, 32'h0, 4'h2, q);
        u_host.xfer(1'b0, 8'h04, 32'h0, 4'h0, q);
        check("cmd lane1", q, 32'h0000_0007);
        check("io off", io_en, 1'b0);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        t_reset();
        t_write();
        t_errors();
        t_rereset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
